// ===== verilog/fwsr_regs.vh
`ifndef FWSR_REGS_VH
`define FWSR_REGS_VH

// ----------------------------------------------------------------
// Status bit positions on the flash data bus
// ----------------------------------------------------------------
`define FWSR_BIT_POLL 7
`define FWSR_BIT_TOGGLE 6
`define FWSR_BIT_TLIMIT 5
`define FWSR_BIT_WINDOW 3
`define FWSR_BIT_SECTOG 2

// ----------------------------------------------------------------
// Command data words written to the flash
// ----------------------------------------------------------------
`define FWSR_CMD_RESET 16'h00f0
`define FWSR_CMD_SECTOR_ERASE 16'h0030

// ----------------------------------------------------------------
// User operation codes and results
// ----------------------------------------------------------------
`define FWSR_OP_POLL 2'h0
`define FWSR_OP_ADD_ERASE 2'h1
`define FWSR_OP_RESET 2'h2
`define FWSR_OP_READ 2'h3
`define FWSR_RES_OK 2'h0
`define FWSR_RES_FAIL 2'h1
`define FWSR_RES_REJECT 2'h2
`define FWSR_RES_MAYBE_LOST 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FWSR_CLK_PERIOD_NS 25
`define FWSR_T_STROBE_NS 100
`define FWSR_STROBE_CYC ((`FWSR_T_STROBE_NS + `FWSR_CLK_PERIOD_NS - 1) / `FWSR_CLK_PERIOD_NS)
`define FWSR_T_WINDOW_NS 50000
`define FWSR_WINDOW_CYC (`FWSR_T_WINDOW_NS / `FWSR_CLK_PERIOD_NS)
`define FWSR_SYNC_CYC 2

`endif

// ===== verilog/fwsr_bus_cycle.v
`timescale 1ns/100ps
`include "fwsr_regs.vh"

// One asynchronous read or write cycle on the flash pins
module fwsr_bus_cycle #(
  parameter ADDR_W = 20,
  parameter DATA_W = 16,
  parameter STROBE_CYC = `FWSR_STROBE_CYC
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_start,
  input wire i_write,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  input wire [DATA_W-1:0] i_dq,
  output reg [ADDR_W-1:0] o_addr,
  output reg [DATA_W-1:0] o_dq,
  output reg o_dq_oe,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n,
  output reg [DATA_W-1:0] o_rdata,
  output reg o_done
);

  reg [DATA_W-1:0] dq_s1_r;
  reg [DATA_W-1:0] dq_s2_r;
  reg [7:0] cnt_r;
  reg active_r;
  reg write_r;

  // Read strobe is stretched by the synchroniser depth, cut to the counter on purpose
  localparam [31:0] READ_CYC = STROBE_CYC + `FWSR_SYNC_CYC;

  // --------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------
  always @(posedge i_clk)
  begin
    dq_s1_r <= i_dq;
    dq_s2_r <= dq_s1_r;
  end

  // --------------------------------------------------------------
  // Cycle sequencer
  // --------------------------------------------------------------
  // Reads hold OE for two extra cycles so the synchroniser sees data
  always @(posedge i_clk)
  begin
    o_done <= 1'b0;
    if (!i_reset_n)
    begin
      o_addr <= {ADDR_W{1'b0}};
      o_dq <= {DATA_W{1'b0}};
      o_dq_oe <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_rdata <= {DATA_W{1'b0}};
      cnt_r <= 8'h00;
      active_r <= 1'b0;
      write_r <= 1'b0;
    end
    else if (!active_r)
    begin
      if (i_start)
      begin
        active_r <= 1'b1;
        write_r <= i_write;
        o_addr <= i_addr;
        o_dq <= i_wdata;
        o_dq_oe <= i_write;
        o_ce_n <= 1'b0;
        o_oe_n <= i_write;
        o_we_n <= ~i_write;
        cnt_r <= i_write ? STROBE_CYC[7:0] : READ_CYC[7:0];
      end
    end
    else if (cnt_r > 8'h01)
      cnt_r <= cnt_r - 8'h01;
    else
    begin
      // Release strobes; data stays driven one more cycle for hold
      active_r <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_done <= 1'b1;
      if (!write_r)
        o_rdata <= dq_s2_r;
    end
    if (i_reset_n && !active_r && !i_start)
      o_dq_oe <= 1'b0;
  end

endmodule // fwsr_bus_cycle

// ===== verilog/fwsr_ctrl.v
`timescale 1ns/100ps
`include "fwsr_regs.vh"

module fwsr_ctrl #(
  parameter ADDR_W = 20,
  parameter DATA_W = 16,
  parameter WINDOW_CYC = `FWSR_WINDOW_CYC
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_req,
  input wire [1:0] i_op,
  input wire [ADDR_W-1:0] i_op_addr,
  input wire i_skip_window,
  input wire [DATA_W-1:0] i_dq,
  input wire i_ready_busy_output,
  output wire [ADDR_W-1:0] o_addr,
  output wire [DATA_W-1:0] o_dq,
  output wire o_dq_oe,
  output wire o_ce_n,
  output wire o_oe_n,
  output wire o_we_n,
  output reg o_busy,
  output reg o_done,
  output reg [1:0] o_result,
  output reg [DATA_W-1:0] o_rdata,
  output reg o_flash_ready,
  output reg o_window_open
);

  // One-hot states
  localparam S_IDLE = 9'h001;
  localparam S_RDA = 9'h002;
  localparam S_RDB = 9'h004;
  localparam S_RDC = 9'h008;
  localparam S_PRE = 9'h010;
  localparam S_WR = 9'h020;
  localparam S_CONF = 9'h040;
  localparam S_WIN = 9'h080;
  localparam S_RST = 9'h100;

  reg [8:0] state_r;
  reg [1:0] op_r;
  reg [ADDR_W-1:0] addr_r;
  reg pend_r;
  reg start_r;
  reg write_r;
  reg [DATA_W-1:0] wdata_r;
  reg tog_prev_r;
  reg rb_s1_r;
  reg [15:0] gap_r;
  wire bus_done;
  wire [DATA_W-1:0] bus_rdata;
  wire toggled;
  wire gap_short;

  // --------------------------------------------------------------
  // Pin cycle engine
  // --------------------------------------------------------------
  fwsr_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .STROBE_CYC(`FWSR_STROBE_CYC)
  ) u_bus (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(start_r),
    .i_write(write_r),
    .i_addr(addr_r),
    .i_wdata(wdata_r),
    .i_dq(i_dq),
    .o_addr(o_addr),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_rdata(bus_rdata),
    .o_done(bus_done)
  );

  // Toggle status bit compared against the previous status read
  assign toggled = bus_rdata[`FWSR_BIT_TOGGLE] ^ tog_prev_r;
  assign gap_short = (gap_r < WINDOW_CYC[15:0]);

  // --------------------------------------------------------------
  // Ready/busy synchroniser and erase command spacing timer
  // --------------------------------------------------------------
  // Open-drain pin is pulled high outside, so it arrives as a level
  always @(posedge i_clk)
  begin
    rb_s1_r <= i_ready_busy_output;
    if (!i_reset_n)
    begin
      o_flash_ready <= 1'b1;
      gap_r <= 16'hffff;
    end
    else
    begin
      o_flash_ready <= rb_s1_r;
      // Restarted by every sector erase write, as the device restarts its time-out
      if (state_r == S_WR && bus_done)
        gap_r <= 16'h0000;
      else if (gap_r != 16'hffff)
        gap_r <= gap_r + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------
  // Every status read goes to the caller's address, which must lie in
  // the busy bank and in an erasing sector or the programmed word
  always @(posedge i_clk)
  begin
    start_r <= 1'b0;
    o_done <= 1'b0;
    if (!i_reset_n)
    begin
      state_r <= S_IDLE;
      op_r <= `FWSR_OP_POLL;
      addr_r <= {ADDR_W{1'b0}};
      pend_r <= 1'b0;
      write_r <= 1'b0;
      wdata_r <= {DATA_W{1'b0}};
      tog_prev_r <= 1'b0;
      o_busy <= 1'b0;
      o_result <= `FWSR_RES_OK;
      o_rdata <= {DATA_W{1'b0}};
      o_window_open <= 1'b0;
    end
    else
    begin
      // Launch the bus cycle of the current state once
      if (state_r != S_IDLE && !pend_r)
      begin
        start_r <= 1'b1;
        pend_r <= 1'b1;
        write_r <= (state_r == S_WR) || (state_r == S_RST);
        wdata_r <= (state_r == S_RST) ? `FWSR_CMD_RESET : `FWSR_CMD_SECTOR_ERASE;
      end
      if (bus_done)
      begin
        pend_r <= 1'b0;
        o_rdata <= bus_rdata;
        tog_prev_r <= bus_rdata[`FWSR_BIT_TOGGLE];
      end
      case (state_r)
        S_IDLE:
        begin
          if (i_req)
          begin
            op_r <= i_op;
            addr_r <= i_op_addr;
            o_busy <= 1'b1;
            if (i_op == `FWSR_OP_RESET)
              state_r <= S_RST;
            else if (i_op == `FWSR_OP_ADD_ERASE)
              // Skipping is only safe while commands stay inside the window
              state_r <= (i_skip_window && gap_short) ? S_WR : S_PRE;
            else
              state_r <= S_RDA;
          end
        end
        S_RDA:
        begin
          if (bus_done)
          begin
            if (op_r == `FWSR_OP_READ)
              state_r <= S_IDLE;
            else
              state_r <= S_RDB;
            if (op_r == `FWSR_OP_READ)
              o_busy <= 1'b0;
            if (op_r == `FWSR_OP_READ)
              o_done <= 1'b1;
            o_result <= `FWSR_RES_OK;
          end
        end
        S_RDB:
        begin
          if (bus_done)
          begin
            if (!toggled)
            begin
              // Stopped toggling: finished; the bank reads array data again
              state_r <= S_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_result <= `FWSR_RES_OK;
            end
            else if (bus_rdata[`FWSR_BIT_TLIMIT])
              state_r <= S_RDC;
          end
        end
        S_RDC:
        begin
          if (bus_done)
          begin
            // Toggling may have stopped just as the limit flag rose
            if (toggled)
              state_r <= S_RST;
            else
            begin
              state_r <= S_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_result <= `FWSR_RES_OK;
            end
          end
        end
        S_PRE:
        begin
          if (bus_done)
          begin
            o_window_open <= ~bus_rdata[`FWSR_BIT_WINDOW];
            if (bus_rdata[`FWSR_BIT_WINDOW])
            begin
              // Erase already running: the device would ignore the command
              state_r <= S_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_result <= `FWSR_RES_REJECT;
            end
            else
              state_r <= S_WR;
          end
        end
        S_WR:
        begin
          if (bus_done)
          begin
            if (i_skip_window && gap_short)
            begin
              state_r <= S_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              o_result <= `FWSR_RES_OK;
            end
            else
              state_r <= S_CONF;
          end
        end
        S_CONF:
        begin
          // One status read is taken before the window flag read; its data is not checked
          if (bus_done)
            state_r <= S_WIN;
        end
        S_WIN:
        begin
          if (bus_done)
          begin
            state_r <= S_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_window_open <= ~bus_rdata[`FWSR_BIT_WINDOW];
            o_result <= bus_rdata[`FWSR_BIT_WINDOW] ? `FWSR_RES_MAYBE_LOST
                                                    : `FWSR_RES_OK;
          end
        end
        S_RST:
        begin
          if (bus_done)
          begin
            state_r <= S_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_result <= (op_r == `FWSR_OP_RESET) ? `FWSR_RES_OK : `FWSR_RES_FAIL;
          end
        end
        default:
        begin
          state_r <= S_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

endmodule // fwsr_ctrl

// ===== verification/fwsr_ctrl_assertions.sv
`timescale 1ns/100ps
// ------------------------------------------------
// Pin and handshake checks on the controller
// ------------------------------------------------
module fwsr_ctrl_chk #(
  parameter ADDR_W = 20
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_req,
  input wire [ADDR_W-1:0] o_addr,
  input wire o_dq_oe,
  input wire o_ce_n,
  input wire o_oe_n,
  input wire o_we_n,
  input wire o_busy,
  input wire o_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Strobe shapes: read 6 cycles, write 4 cycles
  sequence s_read;
    !o_oe_n[*6] ##1 o_oe_n;
  endsequence
  sequence s_write;
    !o_we_n[*4] ##1 o_we_n;
  endsequence
  a_req_taken: assert property (i_req && !o_busy |=> o_busy)
    else $error("request not taken");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_frees: assert property ($fell(o_busy) |-> o_done)
    else $error("busy fell without done");
  a_read_strobe: assert property ($fell(o_oe_n) |-> s_read)
    else $error("read strobe length wrong");
  a_write_strobe: assert property ($fell(o_we_n) |-> s_write)
    else $error("write strobe length wrong");
  a_write_drives: assert property (!o_we_n |-> o_dq_oe && !o_ce_n)
    else $error("write without data drive");
  a_read_released: assert property (!o_oe_n |-> !o_dq_oe && o_we_n)
    else $error("read while driving data");
  a_idle_pins: assert property (!o_busy |-> o_ce_n && o_oe_n && o_we_n)
    else $error("pins active while idle");
  a_addr_stable: assert property (!o_ce_n && !$past(o_ce_n) |-> $stable(o_addr))
    else $error("address moved in a cycle");
endmodule // fwsr_ctrl_chk

bind fwsr_ctrl fwsr_ctrl_chk #(.ADDR_W(ADDR_W)) u_fwsr_ctrl_chk (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_req(i_req), .o_addr(o_addr), .o_dq_oe(o_dq_oe),
  .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_busy(o_busy), .o_done(o_done));

// ===== verification/fwsr_flash_model.sv
`timescale 1ns/100ps
// ------------------------------------------------
// Flash device: status bits and erase window
// ------------------------------------------------
module fwsr_flash_model #(
  parameter WIN = 60
)
(
  input wire i_clk,
  input wire [1:0] i_mode,
  input wire [19:0] i_addr,
  input wire [15:0] i_dq,
  input wire i_ce_n,
  input wire i_oe_n,
  input wire i_we_n,
  output wire [15:0] o_dq,
  output wire o_ready_busy
);
  reg tog_r = 1'b0;
  reg clr_r = 1'b0;
  reg sec_r = 1'b0;
  reg oe_q_r = 1'b1;
  reg we_q_r = 1'b1;
  reg [15:0] last_r = 16'h0000;
  integer win_r = 0;
  // Mode 1 sector erase, mode 2 a program of a one over a zero, mode 3 erase suspended
  wire susp = (i_mode == 2'h3);
  wire busy = (i_mode == 2'h1 || i_mode == 2'h2) && !clr_r;
  wire fail = (i_mode == 2'h2);
  wire wr = we_q_r && !i_we_n && !i_ce_n;
  // Poll bit: zero while erasing, complement of the written one while programming
  wire [15:0] stat = {8'h00, susp, tog_r, fail, 1'b0, win_r == 0, sec_r, 2'b00};
  wire [15:0] rd = (busy || susp) ? stat : (i_addr[15:0] ^ 16'h3c5a);
  // Released bus shows the inverse, not a stale word
  assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last_r;
  assign o_ready_busy = !busy;
  // Toggle on read end; window restarts only while open
  always @(posedge i_clk)
  begin
    oe_q_r <= i_oe_n;
    we_q_r <= i_we_n;
    if (!i_oe_n)
      last_r <= rd;
    if (busy && !oe_q_r && i_oe_n)
      tog_r <= !tog_r;
    // Sector toggle runs for sectors under erase, suspended or not
    if ((i_mode == 2'h1 || susp) && !oe_q_r && i_oe_n)
      sec_r <= !sec_r;
    if (i_mode == 2'h0)
      clr_r <= 1'b0;
    else if (wr && fail && i_dq == 16'h00f0)
      clr_r <= 1'b1;
    if (i_mode != 2'h1)
      win_r <= WIN;
    else if (wr && win_r != 0 && i_dq == 16'h0030)
      win_r <= WIN;
    else if (win_r != 0)
      win_r <= win_r - 1;
  end
endmodule // fwsr_flash_model

// ===== verification/flash_write_status_reporting_test.sv
`timescale 1ns/100ps
`include "fwsr_regs.vh"
module flash_write_status_reporting_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg req = 1'b0;
  reg [1:0] op = 2'h0;
  reg [19:0] addr = 20'h00000;
  reg skip = 1'b0;
  reg [1:0] mode = 2'h0;
  reg [19:0] a;
  reg sb;
  integer err_count = 0;
  integer samples_checked = 0;
  integer i;
  wire [19:0] fa;
  wire [15:0] cdq, mdq, bus, rdata;
  wire [1:0] res;
  wire oe, ce_n, oe_n, we_n, rb, busy, done, rdy, wopen;
  // Data bus: host drives only while enabled
  assign bus = oe ? cdq : mdq;
  always #12.5 clk = ~clk;
  fwsr_ctrl #(.WINDOW_CYC(40)) u_fwsr_ctrl (.i_clk(clk), .i_reset_n(rst_n), .i_req(req),
    .i_op(op), .i_op_addr(addr), .i_skip_window(skip), .i_dq(bus),
    .i_ready_busy_output(rb), .o_addr(fa), .o_dq(cdq), .o_dq_oe(oe), .o_ce_n(ce_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_busy(busy), .o_done(done), .o_result(res),
    .o_rdata(rdata), .o_flash_ready(rdy), .o_window_open(wopen));
  fwsr_flash_model u_fwsr_flash_model (.i_clk(clk), .i_mode(mode), .i_addr(fa),
    .i_dq(bus), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(mdq),
    .o_ready_busy(rb));
  function [15:0] arr(input [19:0] x);
    arr = x[15:0] ^ 16'h3c5a;
  endfunction
  task chk_val(input [15:0] got, input [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task chk_bit(input got, input exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask
  task stop_test;
  begin
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // One user operation, bounded wait for done
  task run_op(input [1:0] o, input [19:0] ad, input s, input [1:0] exp);
    integer n;
  begin
    @(posedge clk);
    req <= 1'b1;
    op <= o;
    addr <= ad;
    skip <= s;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    // A hang counts as a failure and ends the run at once
    if (n >= 2000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
    else
      chk_val({14'h0000, res}, {14'h0000, exp});
  end
  endtask
  initial
  begin
    #(25 * 20000);
    err_count = err_count + 1;
    stop_test;
  end
  initial
  begin
    i = $urandom(88);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_bit(busy, 1'b0);
    chk_bit(rdy, 1'b1);
    // Idle bank: random reads return array words
    for (i = 0; i < 6; i = i + 1)
    begin
      a = $urandom;
      run_op(`FWSR_OP_READ, a, 1'b0, `FWSR_RES_OK);
      chk_val(rdata, arr(a));
    end
    run_op(`FWSR_OP_POLL, a, 1'b0, `FWSR_RES_OK);
    // Failing program: limit flag, reset written, ready again
    @(posedge clk);
    mode <= 2'h2;
    repeat (6) @(posedge clk);
    #1;
    chk_bit(rdy, 1'b0);
    run_op(`FWSR_OP_POLL, a, 1'b0, `FWSR_RES_FAIL);
    repeat (6) @(posedge clk);
    #1;
    chk_bit(rdy, 1'b1);
    // Sector erase window: add, skip, restart, then close
    @(posedge clk);
    mode <= 2'h0;
    @(posedge clk);
    mode <= 2'h1;
    run_op(`FWSR_OP_ADD_ERASE, a, 1'b0, `FWSR_RES_OK);
    chk_bit(wopen, 1'b1);
    run_op(`FWSR_OP_ADD_ERASE, a, 1'b1, `FWSR_RES_OK);
    run_op(`FWSR_OP_ADD_ERASE, a, 1'b0, `FWSR_RES_OK);
    repeat (80) @(posedge clk);
    run_op(`FWSR_OP_ADD_ERASE, a, 1'b0, `FWSR_RES_REJECT);
    chk_bit(wopen, 1'b0);
    // Erase suspended: ready high, steady toggle bit, sector toggle still moving
    @(posedge clk);
    mode <= 2'h3;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(rdy, 1'b1);
    run_op(`FWSR_OP_POLL, a, 1'b0, `FWSR_RES_OK);
    chk_bit(rdata[7], 1'b1);
    sb = rdata[2];
    run_op(`FWSR_OP_READ, a, 1'b0, `FWSR_RES_OK);
    chk_bit(rdata[2], ~sb);
    @(posedge clk);
    mode <= 2'h0;
    run_op(`FWSR_OP_RESET, a, 1'b0, `FWSR_RES_OK);
    stop_test;
  end
endmodule // flash_write_status_reporting_test
